/* hw/aatlb_adjust_top.sv */
// aatlb_adjust_top: local-mode address adjustment with eight translation
// registers, per-entry match circuits, recency matrix and console display.
// assumes the microprogram clears the matrix before emulation, computes the
// real address on the adder result bus and repeats an access after a refill;
// the entry-select switch is an asynchronous console pin.
// several matching entries cannot arise from refills; lowest index would win.
//
// Overview of operation
// - eight 26-bit local-to-real translation registers
// - local address in byte 0 and upper byte 1
// - local field loaded from logical address register
// - real field in bytes 2-3, from adder bus
// - refill writes the entry the matrix selects
// - switch selects entry for console display
// - recency state is 28 pairwise latches
// - matrix state shown as status byte 2
// - refill stores real and local address together
// - every hit updates the recency matrix, except in a cycle with a clear
// - compare local address against entry bytes 0-1
// - hit sets row n, clears column n
// - match lines shown as status byte 3
// - adjust only in local mode, else normal
// - local-mode miss traps to refill routine address
// - oldest entry has zero row, ones column
`timescale 1ns/10ps
module aatlb_adjust_top (
  // clock and reset
  input  wire logic                               clk,
  input  wire logic                               resetn,
  input  wire logic                               clkEnable,
  // storage access from the processor
  input  wire logic                               localMode,
  input  wire logic                               accessValid,
  input  wire logic [aatlb_pkg::ADDR_W-1:0]       logicalAddress,
  // refill from the microprogram
  input  wire logic                               refillWrite,
  input  wire logic [aatlb_pkg::HALF_W-1:0]       adderResult,
  input  wire logic                               recencyClear,
  // adjusted address and trap
  output logic      [aatlb_pkg::ADDR_W-1:0]       storageAddress,
  output logic                                    addressAdjusted,
  output logic                                    accessDone,
  output logic                                    trapRequest,
  output logic      [15:0]                        trapAddress,
  // console display
  input  wire logic [aatlb_pkg::INDEX_W-1:0]      entrySelectPin,
  input  wire logic                               displayRead,
  input  wire logic [7:0]                         displayGroup,
  output logic      [31:0]                        displayData,
  output logic                                    displayValid
);

  localparam int EW = aatlb_pkg::ENTRY_W;
  localparam int EC = aatlb_pkg::ENTRY_COUNT;
  localparam int IW = aatlb_pkg::INDEX_W;
  localparam int HW = aatlb_pkg::HALF_W;

  // entry-select switch: three stages, accepted once stages 2 and 3 agree
  logic [IW-1:0] selSync1;
  logic [IW-1:0] selSync2;
  logic [IW-1:0] selSync3;
  logic [IW-1:0] entrySelect;
  logic [IW-1:0] next_selSync1;
  logic [IW-1:0] next_selSync2;
  logic [IW-1:0] next_selSync3;
  logic [IW-1:0] next_entrySelect;

  // a switch caught mid-travel never reaches the display select
  always_comb begin
    next_selSync1    = entrySelectPin;
    next_selSync2    = selSync1;
    next_selSync3    = selSync2;
    next_entrySelect = entrySelect;
    if (selSync2 == selSync3) begin
      next_entrySelect = selSync3;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      selSync1    <= aatlb_pkg::INDEX_RESET;
      selSync2    <= aatlb_pkg::INDEX_RESET;
      selSync3    <= aatlb_pkg::INDEX_RESET;
      entrySelect <= aatlb_pkg::INDEX_RESET;
    end else if (clkEnable) begin
      selSync1    <= next_selSync1;
      selSync2    <= next_selSync2;
      selSync3    <= next_selSync3;
      entrySelect <= next_entrySelect;
    end
  end

  // translation registers and recency matrix
  logic [EC*EW-1:0]                 entriesFlat;
  logic [EW-1:0]                    selectedEntry;
  logic [EW-1:0]                    refillEntry;
  logic [aatlb_pkg::PAIR_COUNT-1:0] matrix;
  logic [IW-1:0]                    victimIndex;
  logic                             hitAny;
  logic [IW-1:0]                    hitIndex;

  always_comb begin
    refillEntry = aatlb_pkg::ENTRY_RESET;
    refillEntry[aatlb_pkg::LOCAL_MSB:aatlb_pkg::LOCAL_LSB] =
      logicalAddress[aatlb_pkg::ADDR_W-1 -: HW];
    refillEntry[aatlb_pkg::REAL_MSB:aatlb_pkg::REAL_LSB] = adderResult;
    // valid bit keeps cleared entries from matching local address zero
    refillEntry[aatlb_pkg::VALID_BIT] = 1'b1;
  end

  aatlb_entry_store i_aatlb_entry_store (
    .clk         (clk),
    .resetn      (resetn),
    .clkEnable   (clkEnable),
    .writeEnable (refillWrite),
    .writeIndex  (victimIndex),
    .writeData   (refillEntry),
    .readIndex   (entrySelect),
    .readData    (selectedEntry),
    .entriesFlat (entriesFlat)
  );

  // a clear wins over a hit in the same cycle
  aatlb_recency_matrix i_aatlb_recency_matrix (
    .clk         (clk),
    .resetn      (resetn),
    .clkEnable   (clkEnable),
    .clearAll    (recencyClear),
    .hitValid    (hitAny),
    .hitIndex    (hitIndex),
    .matrix      (matrix),
    .victimIndex (victimIndex)
  );

  // match circuits, one per entry
  // match lines ignore localMode so the console can show them at any time
  logic          lookupActive;
  logic [EC-1:0] matchLines;
  logic [HW-1:0] localPart;
  logic [HW-1:0] realParts [EC];

  assign lookupActive = localMode && accessValid;
  assign localPart    = logicalAddress[aatlb_pkg::ADDR_W-1 -: HW];

  genvar g;
  generate
    for (g = 0; g < EC; g++) begin : gMatch
      logic [EW-1:0] ent;
      logic [HW-1:0] entLocal;
      logic          entValid;
      assign ent           = entriesFlat[g*EW +: EW];
      assign entLocal      = ent[aatlb_pkg::LOCAL_MSB:aatlb_pkg::LOCAL_LSB];
      assign entValid      = ent[aatlb_pkg::VALID_BIT];
      assign realParts[g]  = ent[aatlb_pkg::REAL_MSB:aatlb_pkg::REAL_LSB];
      assign matchLines[g] = entValid && entLocal == localPart;
    end
  endgenerate

  // refills only go to a missing address, so one line at most is high;
  // lowest index wins anyway to keep the matrix update well defined
  logic [HW-1:0] hitReal;

  always_comb begin
    hitAny   = 1'b0;
    hitIndex = aatlb_pkg::INDEX_RESET;
    // entry 0 as default keeps the mux free of latches
    hitReal  = realParts[0];
    for (int e = EC - 1; e >= 0; e--) begin
      if (matchLines[e]) begin
        hitIndex = e[IW-1:0];
        hitReal  = realParts[e];
      end
    end
    hitAny = lookupActive && (|matchLines);
  end

  // registered address path and trap
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_NORMAL,
    ACC_HIT,
    ACC_MISS
  } aatlb_access_t;

  aatlb_access_t                accessKind;
  logic [aatlb_pkg::ADDR_W-1:0] next_storageAddress;
  logic                         next_addressAdjusted;
  logic                         next_accessDone;
  logic                         next_trapRequest;

  // outside local mode the entries are ignored entirely
  always_comb begin
    accessKind = ACC_NONE;
    if (accessValid && !localMode) begin
      accessKind = ACC_NORMAL;
    end else if (lookupActive && hitAny) begin
      accessKind = ACC_HIT;
    end else if (lookupActive) begin
      accessKind = ACC_MISS;
    end
  end

  always_comb begin
    next_storageAddress  = storageAddress;
    next_addressAdjusted = 1'b0;
    next_accessDone      = 1'b0;
    next_trapRequest     = 1'b0;
    case (accessKind)
      ACC_NORMAL: begin
        next_storageAddress = logicalAddress;
        next_accessDone     = 1'b1;
      end
      ACC_HIT: begin
        next_storageAddress  = {hitReal, logicalAddress[aatlb_pkg::OFFSET_W-1:0]};
        next_addressAdjusted = 1'b1;
        next_accessDone      = 1'b1;
      end
      ACC_MISS: begin
        // the access is not performed; the refill routine repeats it
        next_trapRequest = 1'b1;
      end
      default: begin
        next_trapRequest = 1'b0;
      end
    endcase
  end

  // with clkEnable low every pulse holds as it stands
  always_ff @(posedge clk) begin
    if (!resetn) begin
      storageAddress  <= aatlb_pkg::ADDR_RESET;
      addressAdjusted <= 1'b0;
      accessDone      <= 1'b0;
      trapRequest     <= 1'b0;
    end else if (clkEnable) begin
      storageAddress  <= next_storageAddress;
      addressAdjusted <= next_addressAdjusted;
      accessDone      <= next_accessDone;
      trapRequest     <= next_trapRequest;
    end
  end

  // fixed entry point; meaningful only while trapRequest is high
  assign trapAddress = aatlb_pkg::TRAP_ADDR;

  // console display: full matrix row of the selected entry, rebuilt from
  // the triangle, since 28 latches cannot fit one byte
  logic [7:0]    matrixRow;
  logic [HW-1:0] shownLocal;
  logic [HW-1:0] shownReal;
  logic [31:0]   next_displayData;
  logic          next_displayValid;

  // entry data lag a refill by one cycle through the store's read register
  assign shownLocal = selectedEntry[aatlb_pkg::LOCAL_MSB:aatlb_pkg::LOCAL_LSB];
  assign shownReal  = selectedEntry[aatlb_pkg::REAL_MSB:aatlb_pkg::REAL_LSB];

  always_comb begin
    matrixRow = 8'h00;
    for (int j = 0; j < EC; j++) begin
      if (j > int'(entrySelect)) begin
        matrixRow[j] = matrix[aatlb_pkg::pairIndex(int'(entrySelect), j)];
      end else if (j < int'(entrySelect)) begin
        matrixRow[j] = !matrix[aatlb_pkg::pairIndex(j, int'(entrySelect))];
      end
    end
  end

  always_comb begin
    next_displayData  = displayData;
    next_displayValid = 1'b0;
    if (displayRead) begin
      next_displayValid = 1'b1;
      case (displayGroup)
        aatlb_pkg::GROUP_ENTRY: begin
          next_displayData = {shownLocal, 4'h0, shownReal, 4'h0};
        end
        aatlb_pkg::GROUP_STATUS: begin
          next_displayData = aatlb_pkg::WORD_RESET;
          next_displayData[aatlb_pkg::BYTE2_LSB +: aatlb_pkg::BYTE_W] = matrixRow;
          next_displayData[aatlb_pkg::BYTE3_LSB +: aatlb_pkg::BYTE_W] = matchLines;
        end
        // unknown groups read as zero but still answer
        default: begin
          next_displayData = aatlb_pkg::WORD_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      displayData  <= aatlb_pkg::WORD_RESET;
      displayValid <= 1'b0;
    end else if (clkEnable) begin
      displayData  <= next_displayData;
      displayValid <= next_displayValid;
    end
  end

endmodule : aatlb_adjust_top

/* hw/aatlb_entry_store.sv */
// aatlb_entry_store: eight translation registers with one write port
// assumes the writer picks the slot; display read data come from a register
`timescale 1ns/10ps
module aatlb_entry_store (
  // clock and reset
  input  wire logic                                             clk,
  input  wire logic                                             resetn,
  input  wire logic                                             clkEnable,
  // write port
  input  wire logic                                             writeEnable,
  input  wire logic [aatlb_pkg::INDEX_W-1:0]                    writeIndex,
  input  wire logic [aatlb_pkg::ENTRY_W-1:0]                    writeData,
  // display read port
  input  wire logic [aatlb_pkg::INDEX_W-1:0]                    readIndex,
  output logic      [aatlb_pkg::ENTRY_W-1:0]                    readData,
  // all entries for the match circuits
  output logic      [aatlb_pkg::ENTRY_COUNT*aatlb_pkg::ENTRY_W-1:0] entriesFlat
);

  logic [aatlb_pkg::ENTRY_W-1:0] mem      [aatlb_pkg::ENTRY_COUNT];
  logic [aatlb_pkg::ENTRY_W-1:0] next_mem [aatlb_pkg::ENTRY_COUNT];
  logic [aatlb_pkg::ENTRY_W-1:0] next_readData;

  always_comb begin
    for (int e = 0; e < aatlb_pkg::ENTRY_COUNT; e++) begin
      next_mem[e] = mem[e];
    end
    if (writeEnable) begin
      next_mem[writeIndex] = writeData;
    end
    next_readData = mem[readIndex];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int e = 0; e < aatlb_pkg::ENTRY_COUNT; e++) begin
        mem[e] <= aatlb_pkg::ENTRY_RESET;
      end
      readData <= aatlb_pkg::ENTRY_RESET;
    end else if (clkEnable) begin
      for (int e = 0; e < aatlb_pkg::ENTRY_COUNT; e++) begin
        mem[e] <= next_mem[e];
      end
      readData <= next_readData;
    end
  end

  genvar g;
  generate
    for (g = 0; g < aatlb_pkg::ENTRY_COUNT; g++) begin : gFlat
      assign entriesFlat[g*aatlb_pkg::ENTRY_W +: aatlb_pkg::ENTRY_W] = mem[g];
    end
  endgenerate

endmodule : aatlb_entry_store

/* hw/aatlb_pkg.sv */
// aatlb_pkg: constants shared by the local-mode address adjustment block
// assumes a 24-bit storage address whose upper 12 bits form the local address
package aatlb_pkg;

  // entry array geometry
  localparam int ENTRY_COUNT = 8;
  localparam int INDEX_W     = 3;
  localparam int HALF_W      = 12;
  localparam int ENTRY_W     = 26;
  localparam int PAIR_COUNT  = 28;

  // field positions inside one entry
  localparam int LOCAL_MSB = 25;
  localparam int LOCAL_LSB = 14;
  localparam int REAL_MSB  = 13;
  localparam int REAL_LSB  = 2;
  localparam int VALID_BIT = 1;

  // storage address split
  localparam int ADDR_W   = 24;
  localparam int OFFSET_W = 12;

  // values after reset
  localparam logic [ENTRY_W-1:0]    ENTRY_RESET  = 26'h0000000;
  localparam logic [PAIR_COUNT-1:0] MATRIX_RESET = 28'h0000000;
  localparam logic [ADDR_W-1:0]     ADDR_RESET   = 24'h000000;
  localparam logic [31:0]           WORD_RESET   = 32'h00000000;
  localparam logic [INDEX_W-1:0]    INDEX_RESET  = 3'h0;

  // console display groups and byte lanes (byte 0 is the top lane)
  localparam logic [7:0] GROUP_ENTRY  = 8'h2E;
  localparam logic [7:0] GROUP_STATUS = 8'h08;
  localparam int         BYTE2_LSB    = 8;
  localparam int         BYTE3_LSB    = 0;
  localparam int         BYTE_W       = 8;

  // microprogram trap target on a local-mode miss
  localparam logic [15:0] TRAP_ADDR = 16'hD80C;

  // slot of the latch shared by entries i and j, i < j
  function automatic int pairIndex(input int i, input int j);
    pairIndex = (i * (2 * ENTRY_COUNT - i - 1)) / 2 + (j - i - 1);
  endfunction : pairIndex

endpackage : aatlb_pkg

/* hw/aatlb_recency_matrix.sv */
// aatlb_recency_matrix: 28-latch least-recently-used matrix for eight entries
// assumes at most one hit per cycle; one latch per entry pair, upper triangle
`timescale 1ns/10ps
module aatlb_recency_matrix (
  // clock and reset
  input  wire logic                                clk,
  input  wire logic                                resetn,
  input  wire logic                                clkEnable,
  // control
  input  wire logic                                clearAll,
  input  wire logic                                hitValid,
  input  wire logic [aatlb_pkg::INDEX_W-1:0]       hitIndex,
  // state and victim
  output logic      [aatlb_pkg::PAIR_COUNT-1:0]    matrix,
  output logic      [aatlb_pkg::INDEX_W-1:0]       victimIndex
);

  logic [aatlb_pkg::PAIR_COUNT-1:0]  next_matrix;
  logic [aatlb_pkg::ENTRY_COUNT-1:0] oldest;

  // latch (i,j) holds row i / column j; its mirror (j,i) is the complement
  genvar gi, gj;
  generate
    for (gi = 0; gi < aatlb_pkg::ENTRY_COUNT; gi++) begin : gRow
      for (gj = gi + 1; gj < aatlb_pkg::ENTRY_COUNT; gj++) begin : gCol
        localparam int P = aatlb_pkg::pairIndex(gi, gj);
        always_comb begin
          if (clearAll) begin
            next_matrix[P] = 1'b0;
          end else if (hitValid && int'(hitIndex) == gi) begin
            next_matrix[P] = 1'b1;
          end else if (hitValid && int'(hitIndex) == gj) begin
            next_matrix[P] = 1'b0;
          end else begin
            next_matrix[P] = matrix[P];
          end
        end
      end
    end
  endgenerate

  // oldest entry: row all zeros and column all ones
  always_comb begin
    for (int k = 0; k < aatlb_pkg::ENTRY_COUNT; k++) begin
      oldest[k] = 1'b1;
      for (int j = 0; j < aatlb_pkg::ENTRY_COUNT; j++) begin
        if (j > k && matrix[aatlb_pkg::pairIndex(k, j)]) begin
          oldest[k] = 1'b0;
        end
        if (j < k && !matrix[aatlb_pkg::pairIndex(j, k)]) begin
          oldest[k] = 1'b0;
        end
      end
    end
    victimIndex = aatlb_pkg::INDEX_RESET;
    for (int k = aatlb_pkg::ENTRY_COUNT - 1; k >= 0; k--) begin
      if (oldest[k]) begin
        victimIndex = k[aatlb_pkg::INDEX_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      matrix <= aatlb_pkg::MATRIX_RESET;
    end else if (clkEnable) begin
      matrix <= next_matrix;
    end
  end

endmodule : aatlb_recency_matrix

/* testbench/aatlb_adjust_chk.sv */
// aatlb_adjust_chk: port-level assertions for the address adjust top
// assumes one clock domain; bound onto every aatlb_adjust_top
`timescale 1ns/10ps
module aatlb_adjust_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        clkEnable,
  // access and refill
  input wire logic        localMode,
  input wire logic        accessValid,
  input wire logic [23:0] logicalAddress,
  input wire logic        refillWrite,
  input wire logic [11:0] adderResult,
  input wire logic        recencyClear,
  // results
  input wire logic [23:0] storageAddress,
  input wire logic        addressAdjusted,
  input wire logic        accessDone,
  input wire logic        trapRequest,
  input wire logic [15:0] trapAddress,
  // display
  input wire logic        displayRead,
  input wire logic [7:0]  displayGroup,
  input wire logic [31:0] displayData,
  input wire logic        displayValid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence localReq;
    accessValid && clkEnable && localMode;
  endsequence
  // refill, then the missed access repeated at once
  sequence refillThenRepeat;
    refillWrite && clkEnable && !recencyClear ##1
    (accessValid && clkEnable && localMode && logicalAddress[23:12] == $past(logicalAddress[23:12]));
  endsequence

  chk_trap_target: assert property (trapAddress == 16'hD80C)
    else $error("trap target wrong");
  chk_local_answer: assert property (localReq |=> addressAdjusted != trapRequest)
    else $error("local access not answered once");
  chk_normal_path: assert property (accessValid && clkEnable && !localMode |=>
    accessDone && !addressAdjusted && !trapRequest && storageAddress == $past(logicalAddress))
    else $error("normal access altered");
  chk_offset_pass: assert property (addressAdjusted |->
    accessDone && storageAddress[11:0] == $past(logicalAddress[11:0]))
    else $error("offset not passed");
  chk_miss_quiet: assert property (trapRequest |-> !accessDone && !addressAdjusted)
    else $error("miss also completed");
  chk_idle_quiet: assert property (clkEnable && !accessValid |=> !accessDone && !trapRequest)
    else $error("answer without access");
  chk_display_answer: assert property (clkEnable && displayRead |=> displayValid)
    else $error("display not answered");
  chk_entry_layout: assert property (clkEnable && displayRead && displayGroup == 8'h2E |=>
    displayData[19:16] == 4'h0 && displayData[3:0] == 4'h0)
    else $error("entry layout wrong");
  chk_status_upper: assert property (clkEnable && displayRead && displayGroup == 8'h08 |=>
    displayData[31:16] == 16'h0000)
    else $error("status upper bytes set");
  chk_refill_hit: assert property (refillThenRepeat |=>
    addressAdjusted && storageAddress[23:12] == $past(adderResult, 2))
    else $error("refilled entry missed");
endmodule : aatlb_adjust_chk

bind aatlb_adjust_top aatlb_adjust_chk i_aatlb_adjust_chk (.clk(clk), .resetn(resetn),
  .clkEnable(clkEnable), .localMode(localMode), .accessValid(accessValid),
  .logicalAddress(logicalAddress), .refillWrite(refillWrite), .adderResult(adderResult),
  .recencyClear(recencyClear), .storageAddress(storageAddress), .addressAdjusted(addressAdjusted),
  .accessDone(accessDone), .trapRequest(trapRequest), .trapAddress(trapAddress),
  .displayRead(displayRead), .displayGroup(displayGroup), .displayData(displayData),
  .displayValid(displayValid));

/* testbench/aatlb_refill_model.sv */
// aatlb_refill_model: miss refill routine as seen at the block's pins
// assumes trapRequest is a one-cycle pulse; drives on the falling edge
`timescale 1ns/10ps
module aatlb_refill_model #(
  parameter logic [11:0] ADJUST = 12'h2A5
) (
  // clock and pace
  input  wire logic        clk,
  input  wire logic        slow,
  // block side
  input  wire logic        trapRequest,
  input  wire logic [23:0] logicalAddress,
  output logic             refillWrite,
  output logic      [11:0] adderResult
);
  int delay = 0;

  initial begin
    refillWrite = 1'b0;
    adderResult = 12'h000;
  end

  always @(negedge clk) begin
    if (trapRequest) begin
      delay = slow ? 3 : 1;
    end
    if (delay == 1) begin
      refillWrite <= 1'b1;
      adderResult <= logicalAddress[23:12] + ADJUST;
    end else begin
      refillWrite <= 1'b0;
      // released bus: keep it moving so a stale value never looks valid
      adderResult <= ~adderResult;
    end
    if (delay != 0) begin
      delay = delay - 1;
    end
  end
endmodule : aatlb_refill_model

/* testbench/tb_address_adjust_tlb_lru.sv */
// tb_address_adjust_tlb_lru: self-checking bench for the address adjust top
// assumes the refill model answers every trap; inputs change on falling edges
`timescale 1ns/10ps
module tb_address_adjust_tlb_lru;
  localparam logic [11:0] ADJUST = 12'h2A5;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clkEnable = 1'b1;
  logic        localMode = 1'b0;
  logic        accessValid = 1'b0;
  logic [23:0] logicalAddress = 24'h000000;
  logic        refillWrite;
  logic [11:0] adderResult;
  logic        recencyClear = 1'b0;
  logic [23:0] storageAddress;
  logic        addressAdjusted;
  logic        accessDone;
  logic        trapRequest;
  logic [15:0] trapAddress;
  logic [2:0]  entrySelectPin = 3'h0;
  logic        displayRead = 1'b0;
  logic [7:0]  displayGroup = 8'h00;
  logic [31:0] displayData;
  logic        displayValid;
  logic        slow = 1'b0;
  logic [33:0] expQ[$];
  logic [11:0] locT[8];
  logic [11:0] realT[8];
  int          age[$];
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          nextLoc = 1;

  aatlb_adjust_top i_aatlb_adjust_top (.clk(clk), .resetn(resetn), .clkEnable(clkEnable),
    .localMode(localMode), .accessValid(accessValid), .logicalAddress(logicalAddress),
    .refillWrite(refillWrite), .adderResult(adderResult), .recencyClear(recencyClear),
    .storageAddress(storageAddress), .addressAdjusted(addressAdjusted), .accessDone(accessDone),
    .trapRequest(trapRequest), .trapAddress(trapAddress), .entrySelectPin(entrySelectPin),
    .displayRead(displayRead), .displayGroup(displayGroup), .displayData(displayData),
    .displayValid(displayValid));
  aatlb_refill_model #(.ADJUST(ADJUST)) i_aatlb_refill_model (.clk(clk), .slow(slow),
    .trapRequest(trapRequest), .logicalAddress(logicalAddress), .refillWrite(refillWrite),
    .adderResult(adderResult));

  always #10 clk = ~clk;

  // one note per answer; display, trap and access share one stream
  always @(negedge clk) begin
    logic [33:0] got;
    if (accessDone || trapRequest || displayValid) begin
      if (displayValid) got = {2'h0, displayData};
      else if (trapRequest) got = {2'h3, 16'h0000, trapAddress};
      else got = {addressAdjusted ? 2'h1 : 2'h2, 8'h00, storageAddress};
      total_checks++;
      if (expQ.size() == 0 || got !== expQ[0]) begin
        n_mismatch++;
        $display("BAD %0t got %h exp %h", $time, got, expQ.size() ? expQ[0] : 34'h0);
      end
      if (expQ.size() != 0) void'(expQ.pop_front());
    end
  end

  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic idle();
    @(negedge clk);
    accessValid = 1'b0;
    displayRead = 1'b0;
    recencyClear = 1'b0;
  endtask : idle

  task automatic access(input logic [23:0] a, input logic lm, input logic [33:0] e);
    @(negedge clk);
    logicalAddress = a;
    localMode = lm;
    accessValid = 1'b1;
    expQ.push_back(e);
  endtask : access

  // hit keeps accessValid high so calls run back to back
  task automatic hit(input int e, input logic [11:0] off);
    access({locT[e], off}, 1'b1, {2'h1, 8'h00, realT[e], off});
    for (int k = 0; k < age.size(); k++) if (age[k] == e) begin
      age.delete(k);
      break;
    end
    age.push_back(e);
  endtask : hit

  task automatic missRefill();
    logic [23:0] a;
    int v;
    a = {nextLoc[7:0], 4'($urandom), 12'($urandom)};
    nextLoc++;
    access(a, 1'b1, {2'h3, 16'h0000, 16'hD80C});
    idle();
    for (int i = 0; i < 8 && refillWrite !== 1'b1; i++) @(posedge clk);
    if (refillWrite !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    v = age.pop_front();
    locT[v] = a[23:12];
    realT[v] = a[23:12] + ADJUST;
    hit(v, a[11:0]);
  endtask : missRefill

  task automatic show(input logic [7:0] g, input logic [2:0] s, input logic [31:0] e);
    @(negedge clk);
    entrySelectPin = s;
    // the switch is asynchronous and needs a few edges to settle
    repeat (5) @(negedge clk);
    displayGroup = g;
    displayRead = 1'b1;
    expQ.push_back({2'h0, e});
    idle();
  endtask : show

  function automatic logic [31:0] status(input int s);
    logic [31:0] r;
    int ps;
    r = 32'h00000000;
    ps = 0;
    for (int j = 0; j < 8; j++) if (age[j] == s) ps = j;
    for (int j = 0; j < 8; j++) begin
      r[8 + age[j]] = (j < ps);
      r[age[j]] = (locT[age[j]] == logicalAddress[23:12]);
    end
    return r;
  endfunction : status

  initial begin
    logic [23:0] a;
    logic [7:0] g;
    void'($urandom(53343));
    for (int i = 0; i < 8; i++) age.push_back(i);
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk) recencyClear = 1'b1;
    idle();
    a = 24'($urandom);
    access(a, 1'b0, {2'h2, 8'h00, a});
    for (int i = 0; i < 8; i++) begin
      slow = 1'($urandom);
      missRefill();
    end
    idle();
    for (int e = 0; e < 8; e++) show(8'h2E, 3'(e), {locT[e], 4'h0, realT[e], 4'h0});
    repeat (40) begin
      slow = 1'($urandom);
      case ($urandom % 5)
        0: missRefill();
        1: begin
          a = 24'($urandom);
          access(a, 1'b0, {2'h2, 8'h00, a});
        end
        default: hit($urandom % 8, 12'($urandom));
      endcase
    end
    idle();
    for (int s = 0; s < 8; s++) show(8'h08, 3'(s), status(s));
    do g = 8'($urandom); while (g == 8'h2E || g == 8'h08);
    show(g, 3'h0, 32'h00000000);
    @(negedge clk) clkEnable = 1'b0;
    a = 24'($urandom);
    access(a, 1'b0, {2'h2, 8'h00, a});
    repeat (3) @(negedge clk);
    clkEnable = 1'b1;
    idle();
    @(negedge clk) recencyClear = 1'b1;
    idle();
    age.delete();
    for (int i = 0; i < 8; i++) age.push_back(i);
    show(8'h08, 3'h0, status(0));
    missRefill();
    idle();
    show(8'h2E, 3'h0, {locT[0], 4'h0, realT[0], 4'h0});
    repeat (3) idle();
    if (expQ.size() != 0) n_mismatch++;
    conclude();
  end
endmodule : tb_address_adjust_tlb_lru
